// file: sim/adc_ctrl_properties.sv
// ============================================================================
// port checker for the converter control
module adc_ctrl_properties (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // trigger and host strobes
  input wire logic CONVERSION_TRIGGER,
  input wire logic CS_N,
  input wire logic RD_N,
  // device outputs
  input wire logic [simsample_pkg::CHAN_N-1:0] HOLD,
  input wire logic [simsample_pkg::CHAN_N-1:0] CONVERTING,
  input wire logic DONE_N,
  input wire logic RESULT_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  // hold span: from 76 ticks of 40 cycles up to just under the trigger limit
  localparam int SPAN_MIN = 3040;
  localparam int SPAN_MAX = 3246;
  logic [11:0] span;
  logic [11:0] next_span;
  // span counts cycles in hold, saturating
  always_comb begin
    next_span = span;
    if (HOLD == 4'h0) begin
      next_span = 12'h000;
    end else if (span != 12'hfff) begin
      next_span = span + 12'h001;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    span <= RSTN ? next_span : 12'h000;
  end
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  sequence trig_rise;
    $rose(CONVERSION_TRIGGER) && HOLD == 4'h0;
  endsequence
  sequence all_held;
    HOLD == 4'hf;
  endsequence
  oe_gate_a: assert property (!RESULT_OE_N |-> $past(CS_N) == 1'b0 && $past(RD_N) == 1'b0)
    else $error("bus driven without both strobes");
  oe_follow_a: assert property (!CS_N && !RD_N |=> !RESULT_OE_N)
    else $error("bus not driven on read");
  start_hold_a: assert property (trig_rise |-> ##[1:6] all_held)
    else $error("trigger did not start hold");
  hold_group_a: assert property (HOLD == 4'hf || HOLD == 4'h0)
    else $error("holds not switched together");
  chan_first_a: assert property ($rose(|CONVERTING) |-> CONVERTING == 4'h1 && HOLD == 4'hf)
    else $error("first channel not one");
  chan_step_a: assert property (CONVERTING != 4'h0 && $past(CONVERTING) != 4'h0
    && CONVERTING != $past(CONVERTING) |-> CONVERTING == ($past(CONVERTING) << 1))
    else $error("channel order broken");
  done_drop_a: assert property ($fell(DONE_N) |-> HOLD == 4'h0 && $past(HOLD) == 4'hf)
    else $error("done without track return");
  done_span_a: assert property ($fell(DONE_N) |-> span >= SPAN_MIN && span <= SPAN_MAX)
    else $error("conversion length off");
  read_clear_a: assert property ($fell(RESULT_OE_N) |-> DONE_N)
    else $error("done flag kept on read");
  restart_a: assert property ($rose(HOLD[0]) |-> DONE_N)
    else $error("done low during conversion");
endmodule : adc_ctrl_properties

bind simsample_adc_ctrl adc_ctrl_properties u_props (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CONVERSION_TRIGGER(CONVERSION_TRIGGER),
  .CS_N(CS_N), .RD_N(RD_N), .HOLD(HOLD), .CONVERTING(CONVERTING),
  .DONE_N(DONE_N), .RESULT_OE_N(RESULT_OE_N)
);

// file: sim/four_channel_simsample_adc_ctrl_bench.sv
// ============================================================================
// bench: table of conversions, then hand-written edge cases
module four_channel_simsample_adc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // one row: codes ch4..ch1, oscillator strap, host slowness
  typedef struct {
    logic [3:0][11:0] codes;
    logic tied;
    int hold;
  } case_s;
  case_s rows [3] = '{
    '{'{12'h0fff, 12'h0001, 12'h07ff, 12'h0800}, 1'b1, 0},
    '{'{12'h0f0f, 12'h0000, 12'h05a3, 12'h0a5c}, 1'b0, 3},
    '{'{12'h0123, 12'h0456, 12'h0789, 12'h0abc}, 1'b1, 1}};
  logic [3:0][11:0] fresh = '{12'h0321, 12'h0654, 12'h0987, 12'h0cba};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic conv_clk = 1'b0;
  logic tied = 1'b1;
  logic trig = 1'b0;
  logic [47:0] codes = 48'h0000_0000_0000;
  logic cs_n, rd_n, oe_n, done_n, ok;
  logic [3:0] hold, conv;
  logic [11:0] data, w;
  int failures = 0;
  int checked = 0;
  // clocks: external conversion clock at 2.5 MHz, phase unrelated
  always #5 clk_sys = ~clk_sys;
  initial begin
    #37;
    forever #200 conv_clk = ~conv_clk;
  end
  simsample_adc_ctrl u_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .CONV_CLK(conv_clk),
    .CONV_CLK_TIED(tied), .CONVERSION_TRIGGER(trig), .CS_N(cs_n), .RD_N(rd_n),
    .SAMPLE_CODES(codes), .HOLD(hold), .CONVERTING(conv), .DONE_N(done_n),
    .RESULT_OUT(data), .RESULT_OE_N(oe_n));
  host_model u_host (.clk(clk_sys), .data(data), .oe_n(oe_n), .cs_n(cs_n), .rd_n(rd_n));
  // compare and count
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // trigger pulse, wider than the minimum
  task automatic pulse();
    @(posedge clk_sys);
    trig <= 1'b1;
    repeat (6) @(posedge clk_sys);
    trig <= 1'b0;
  endtask : pulse
  // bounded wait for the done flag, then the tracking state
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) begin
      failures++;
      $display("BAD done wait expected 0 seen %b", done_n);
      final_report();
    end
    chk("hold", 12'h000, hold);
    chk("converting", 12'h000, conv);
  endtask : wait_done
  // n reads; extra reads repeat the last word
  task automatic read_all(input logic [3:0][11:0] c, input int hd, input int n);
    for (int i = 0; i < n; i++) begin
      u_host.access(1'b0, 1'b0, hd, w, ok);
      chk("ack", 12'h001, ok);
      chk("word", c[(i > 3) ? 3 : i], w);
      if (i == 0) begin
        chk("done after read", 12'h001, done_n);
      end
    end
  endtask : read_all
  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    chk("reset hold", 12'h000, hold);
    chk("reset done", 12'h001, done_n);
    chk("reset oe", 12'h001, oe_n);
    rstn <= 1'b1;
    foreach (rows[k]) begin
      codes <= rows[k].codes;
      tied <= rows[k].tied;
      pulse();
      wait_done();
      read_all(rows[k].codes, rows[k].hold, 5);
      $display("row %0d finished", k);
    end
    // retrigger while converting is ignored: done must come on the first trigger's time,
    // well before a restarted sequence could finish
    pulse();
    repeat (300) @(posedge clk_sys);
    pulse();
    repeat (2850) @(posedge clk_sys);
    chk("retrigger ignored", 12'h000, done_n);
    wait_done();
    read_all(rows[2].codes, 0, 1);
    $display("retrigger finished");
    // restart with a word unread, lone strobes never open the bus
    codes <= fresh;
    pulse();
    wait_done();
    u_host.access(1'b0, 1'b1, 0, w, ok);
    chk("select only", 12'h000, ok);
    u_host.access(1'b1, 1'b0, 0, w, ok);
    chk("read only", 12'h000, ok);
    read_all(fresh, 0, 4);
    $display("restart finished");
    final_report();
  end
endmodule : four_channel_simsample_adc_ctrl_bench

// file: sim/host_model.sv
// ============================================================================
// host on the parallel bus: strobes held until the word shows
module host_model (
  // clock
  input wire logic clk,
  // result bus of the device
  input wire logic [11:0] data,
  input wire logic oe_n,
  // host strobes, active low
  output logic cs_n,
  output logic rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus floats while the device is off, so no stale word passes
  wire [11:0] bus = oe_n ? 12'hzzz : data;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  // one access: c and r are the strobe levels, hold adds slow-host cycles
  task automatic access(input logic c, input logic r, input int hold,
                        output logic [11:0] w, output logic ok);
    ok = 1'b0;
    w = 12'hxxx;
    @(posedge clk);
    cs_n <= c;
    rd_n <= r;
    // wait for the bus, bounded
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (!oe_n) begin
        ok = 1'b1;
        w = bus;
      end
    end
    repeat (hold) @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    // idle gap lets the next word load
    repeat (2) @(posedge clk);
  endtask : access
endmodule : host_model

// file: src/result_buffer.sv
// ============================================================================
// two-entry buffer: accepts a word per cycle while not full, drains on ready
module result_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // filling side
  input wire logic in_valid,
  input wire logic [simsample_pkg::RESULT_W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [simsample_pkg::RESULT_W-1:0] out_data,
  // flush resets both pointers and the count; stored words stay
  input wire logic flush
);
  logic [simsample_pkg::RESULT_W-1:0] mem [2]; // storage words
  logic [simsample_pkg::RESULT_W-1:0] next_mem [2];
  logic wr_ptr; // next slot to write
  logic next_wr_ptr;
  logic rd_ptr; // next slot to read
  logic next_rd_ptr;
  logic [1:0] count; // words held, 0..2
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================================================
  // next-state computation
  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush) begin
      // new conversion discards stale words
      next_wr_ptr = 1'b0;
      next_rd_ptr = 1'b0;
      next_count = 2'd0;
    end else begin
      if (push) begin
        next_mem[wr_ptr] = in_data;
        next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
        next_rd_ptr = ~rd_ptr;
      end
      case ({push, pop})
        2'b10: next_count = count + 2'd1;
        2'b01: next_count = count - 2'd1;
        default: next_count = count;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem[0] <= simsample_pkg::RESULT_ZERO;
      mem[1] <= simsample_pkg::RESULT_ZERO;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule : result_buffer

// file: src/simsample_adc_ctrl.sv
// Notes on behaviour
// - done falling returns all holds to track
// - trigger rising edge: hold, start conversion
// - convert channels one through four in order
// - trigger synchronised, independent of select and read
// - active-low done flag shows converter status
// - data driven only while read and select low
// - four reads return channels 1,2,3,4
// - selected only while chip select low
// - external clock, or internal oscillator when tied
// - two's complement, three-state, bit 11 msb; RESULT_OUT is never floated here, RESULT_OE_N low marks when it is valid
// - bit 0 lsb, twelve-bit word
// - store all results; done after fourth
// - sequence takes 78 or 79 edges
// - trigger to done within 32.5 us
// - no direct channel addressing, sequential only
module simsample_adc_ctrl (
  // system clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // conversion clock select: external clock pin, and tie-off strap for oscillator
  input wire logic CONV_CLK,
  input wire logic CONV_CLK_TIED,
  // conversion trigger, asynchronous
  input wire logic CONVERSION_TRIGGER,
  // host strobes, active low
  input wire logic CS_N,
  input wire logic RD_N,
  // converter results per channel, two's complement
  input wire logic [simsample_pkg::RESULT_W*simsample_pkg::CHAN_N-1:0] SAMPLE_CODES,
  // track/hold control, one bit per channel, high means hold
  output logic [simsample_pkg::CHAN_N-1:0] HOLD,
  // channel currently converted, one-hot
  output logic [simsample_pkg::CHAN_N-1:0] CONVERTING,
  // done flag, active low
  output logic DONE_N,
  // result bus: data out and enable, enable low while driving
  output logic [simsample_pkg::RESULT_W-1:0] RESULT_OUT,
  output logic RESULT_OE_N
);
  // ==========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // tracking, waiting for trigger
    ST_CONV = 3'b010, // converting held channels
    ST_DONE = 3'b100  // results ready
  } seq_state_e;

  seq_state_e state; // sequencer state
  seq_state_e next_state;
  logic trig_s1; // first sync stage, read only by trig_s2
  logic trig_s2; // second sync stage
  logic trig_s3; // delayed copy for edge detection
  logic clk_s1; // external conversion clock sync
  logic clk_s2;
  logic clk_s3;
  logic [simsample_pkg::DIV_W-1:0] div_cnt; // internal oscillator divider
  logic [simsample_pkg::DIV_W-1:0] next_div_cnt;
  logic [simsample_pkg::EDGE_W-1:0] edge_cnt; // conversion edges seen
  logic [simsample_pkg::EDGE_W-1:0] next_edge_cnt;
  logic [simsample_pkg::CHAN_W-1:0] conv_chan; // channel being converted
  logic [simsample_pkg::CHAN_W-1:0] next_conv_chan;
  logic [simsample_pkg::CHAN_W-1:0] read_chan; // next channel pushed to buffer
  logic [simsample_pkg::CHAN_W-1:0] next_read_chan;
  logic feed_active; // results still to be queued
  logic next_feed_active;
  logic [simsample_pkg::RESULT_W-1:0] store [simsample_pkg::CHAN_N]; // held results
  logic [simsample_pkg::RESULT_W-1:0] next_store [simsample_pkg::CHAN_N];
  logic [simsample_pkg::CHAN_N-1:0] next_hold;
  logic [simsample_pkg::CHAN_N-1:0] next_converting;
  logic next_done_n;
  logic [simsample_pkg::RESULT_W-1:0] next_result_out;
  logic next_result_oe_n;
  logic rd_prev; // selected and reading last cycle
  logic trig_rise; // synchronised trigger edge
  logic conv_tick; // one conversion clock edge
  logic read_active; // selected and reading
  logic read_start; // first cycle of a read
  logic read_end; // select or read strobe released
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [simsample_pkg::RESULT_W-1:0] buf_out_data;

  // one-hot channel decode, used for the converting indicator only; holds are all set together
  function automatic logic [simsample_pkg::CHAN_N-1:0] chan_onehot(
    input logic [simsample_pkg::CHAN_W-1:0] idx);
    chan_onehot = 4'h1 << idx;
  endfunction : chan_onehot

  assign trig_rise = trig_s2 && !trig_s3;
  assign read_active = !CS_N && !RD_N;
  assign read_start = read_active && !rd_prev;
  assign read_end = !read_active && rd_prev;
  // tied pin picks the divided system clock as oscillator
  assign conv_tick = CONV_CLK_TIED ? (div_cnt == '0) : (clk_s2 && !clk_s3);
  assign buf_in_valid = feed_active;

  // ==========================================================================
  // result queue toward the bus; read pops only when a word ends
  result_buffer u_buf (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .in_valid(buf_in_valid),
    .in_data(store[read_chan]),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_ready(read_end),
    .out_data(buf_out_data),
    .flush(trig_rise)
  );

  // ==========================================================================
  // sequencer next-state logic
  always_comb begin
    next_state = state;
    next_div_cnt = (div_cnt == 6'(simsample_pkg::DIV_CYCLES - 1)) ? '0 : div_cnt + 6'd1;
    next_edge_cnt = edge_cnt;
    next_conv_chan = conv_chan;
    next_read_chan = read_chan;
    next_feed_active = feed_active;
    next_store = store;
    next_hold = HOLD;
    next_converting = '0;
    next_done_n = DONE_N;
    next_result_out = RESULT_OUT;
    next_result_oe_n = !read_active;
    if (read_start && buf_out_valid) begin
      next_result_out = buf_out_data;
    end
    if (read_start && !DONE_N) begin
      next_done_n = 1'b1;
    end
    // queue stored results in channel order
    if (feed_active && buf_in_ready) begin
      next_read_chan = read_chan + 2'd1;
      if (read_chan == 2'(simsample_pkg::CHAN_N - 1)) begin
        next_feed_active = 1'b0;
      end
    end
    case (state)
      ST_IDLE: begin
        // edge acts whatever the select and read strobes do
        if (trig_rise) begin
          next_state = ST_CONV;
          next_hold = '1;
          next_edge_cnt = '0;
          next_conv_chan = '0;
          next_read_chan = '0;
          next_feed_active = 1'b0;
          next_done_n = 1'b1;
        end
      end
      ST_CONV: begin
        next_converting = chan_onehot(conv_chan);
        if (conv_tick) begin
          next_edge_cnt = edge_cnt + 7'd1;
          if (edge_cnt == 7'(simsample_pkg::EDGES_PER_CHAN * (32'(conv_chan) + 1) - 1)) begin
            next_store[conv_chan] = SAMPLE_CODES[conv_chan*simsample_pkg::RESULT_W +:
              simsample_pkg::RESULT_W];
            // stay on the last channel so the indicator never wraps back to channel one
            if (conv_chan != 2'(simsample_pkg::CHAN_N - 1)) begin
              next_conv_chan = conv_chan + 2'd1;
            end
          end
          // final edge of the sequence; trigger sync adds the 79th
          if (edge_cnt == 7'(simsample_pkg::CONV_EDGES - 1)) begin
            next_state = ST_DONE;
            next_done_n = 1'b0;
            next_hold = '0;
            // indicator is clear outside conversion, from the same edge as done
            next_converting = '0;
            next_read_chan = '0;
            next_feed_active = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (trig_rise) begin
          next_state = ST_CONV;
          next_hold = '1;
          next_edge_cnt = '0;
          next_conv_chan = '0;
          next_read_chan = '0;
          next_feed_active = 1'b0;
          next_done_n = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_hold = '0;
      end
    endcase
  end

  // ==========================================================================
  // registers; synchronisers sit here too
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      div_cnt <= '0;
      edge_cnt <= '0;
      conv_chan <= '0;
      read_chan <= '0;
      feed_active <= 1'b0;
      for (int i = 0; i < simsample_pkg::CHAN_N; i++) begin
        store[i] <= simsample_pkg::RESULT_ZERO;
      end
      HOLD <= '0;
      CONVERTING <= '0;
      DONE_N <= simsample_pkg::DONE_IDLE;
      RESULT_OUT <= simsample_pkg::RESULT_ZERO;
      RESULT_OE_N <= 1'b1;
      rd_prev <= 1'b0;
    end else begin
      state <= next_state;
      trig_s1 <= CONVERSION_TRIGGER;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      clk_s1 <= CONV_CLK;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      div_cnt <= next_div_cnt;
      edge_cnt <= next_edge_cnt;
      conv_chan <= next_conv_chan;
      read_chan <= next_read_chan;
      feed_active <= next_feed_active;
      store <= next_store;
      HOLD <= next_hold;
      CONVERTING <= next_converting;
      DONE_N <= next_done_n;
      RESULT_OUT <= next_result_out;
      RESULT_OE_N <= next_result_oe_n;
      rd_prev <= read_active;
    end
  end
endmodule : simsample_adc_ctrl

// file: src/simsample_pkg.sv
package simsample_pkg;
  // ==========================================================================
  // widths
  localparam int unsigned RESULT_W = 12;           // result word, msb is bit 11
  localparam int unsigned CHAN_N = 4;              // channels per cycle
  localparam int unsigned CHAN_W = 2;              // channel index width
  // ==========================================================================
  // conversion timing
  localparam int unsigned CONV_EDGES = 78;         // conversion clock edges, nominal
  localparam int unsigned EDGES_PER_CHAN = 19;     // edges spent on each channel
  localparam int unsigned EDGE_W = 7;              // edge counter width
  localparam real EXT_CLK_MHZ = 2.5;               // reference conversion clock rate
  localparam real SYS_CLK_MHZ = 100.0;             // CLK_SYS rate
  localparam real CONV_MAX_US = 32.5;              // trigger to done, longest
  // system cycles per conversion edge, rounded down so the edge rate never slows
  localparam int unsigned DIV_CYCLES = int'($floor(SYS_CLK_MHZ / EXT_CLK_MHZ));
  localparam int unsigned DIV_W = 6;               // divider counter width
  // longest conversion in system cycles, rounded down
  localparam int unsigned CONV_MAX_CYCLES = int'($floor(CONV_MAX_US * SYS_CLK_MHZ));
  // ==========================================================================
  // pin reset values
  localparam logic DONE_IDLE = 1'b1;               // done flag high when idle
  localparam logic [RESULT_W-1:0] RESULT_ZERO = 12'h000;
endpackage : simsample_pkg
